// *** rtl/refsel_pkg.sv ***
/*
  Shared constants for the reference input selection block: register
  byte addresses, field positions, reset values, mode and state codes.
  Assumes a single 40 MHz oscillator clock domain.
*/
package refsel_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_PRIORITY  = 8'h34;
  localparam logic [7:0] ADDR_SWITCHING = 8'h35;
  localparam logic [7:0] ADDR_HOLDOFF   = 8'h36;
  localparam logic [7:0] ADDR_DIVIDERS  = 8'h37;

  // Field positions (low bit of each field)
  localparam int PRIO0_LSB  = 6;
  localparam int PRIO1_LSB  = 4;
  localparam int BLOCK_BIT  = 6;
  localparam int REVS_BIT   = 5;
  localparam int MODE_LSB   = 2;
  localparam int SEL_LSB    = 0;
  localparam int DIVSEL_LSB = 6;
  localparam int CNTV_LSB   = 0;

  // Values after reset
  localparam logic [1:0] PRIO0_RST  = 2'h3;
  localparam logic [1:0] PRIO1_RST  = 2'h2;
  localparam logic [1:0] MODE_RST   = 2'h0;
  localparam logic [1:0] SEL_RST    = 2'h0;
  localparam logic [7:0] HOLDOFF_RST = 8'h80;
  localparam logic [1:0] DIVSEL_RST = 2'h0;
  localparam logic [1:0] CNTV_RST   = 2'h0;

  // Hold-off tick is the oscillator divided by 2^(base + divider code)
  localparam int HOLDOFF_DIV_EXP_BASE = 15;
  localparam int PRESCALE_W           = 18;

  // Reference input selection modes
  typedef enum logic [1:0] {
    MODE_MANUAL       = 2'b00,
    MODE_AUTO         = 2'b01,
    MODE_SHORT_HOLD   = 2'b10,
    MODE_AUTO_HOLDOFF = 2'b11
  } sel_mode_e;

  // Automatic selection states
  typedef enum logic [1:0] {
    ST_TRACK    = 2'b00,
    ST_HOLDOFF  = 2'b01,
    ST_HOLDOVER = 2'b10
  } auto_state_e;

  // Re-validation period count for a given setting (input divider of one)
  function automatic logic [6:0] revalid_count(input logic [1:0] code);
    logic [6:0] cnt;
    cnt = 7'h02;
    case (code)
      2'b00: cnt = 7'h02;
      2'b01: cnt = 7'h10;
      2'b10: cnt = 7'h20;
      2'b11: cnt = 7'h40;
      default: cnt = 7'h02;
    endcase
    return cnt;
  endfunction : revalid_count

endpackage : refsel_pkg

// *** rtl/holdoff_prescaler.sv ***
/*
  Free-running oscillator prescaler that emits one-cycle hold-off ticks
  at the oscillator rate divided by 2^(EXP_BASE + div_sel).
  Assumes div_sel is steady while a hold-off count is in progress.
*/
`timescale 1ns/1ps
module holdoff_prescaler
  import refsel_pkg::*;
#(
  parameter int EXP_BASE = HOLDOFF_DIV_EXP_BASE
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Control
  input  wire logic       restart,
  input  wire logic [1:0] div_sel,
  // Tick out
  output logic            tick
);

  logic [PRESCALE_W-1:0] count_reg;
  logic [PRESCALE_W-1:0] count_next;
  logic [PRESCALE_W-1:0] tick_mask;
  logic                  tick_next;
  logic                  tick_reg;

  // Mask of the low bits that must all be set to end one divided period
  assign tick_mask  = PRESCALE_W'((1 << (EXP_BASE + int'(div_sel))) - 1);
  assign tick_next  = !restart && ((count_reg & tick_mask) == tick_mask);
  assign count_next = restart ? '0 : count_reg + 1'b1;
  assign tick       = tick_reg;

  // Restart aligns the first tick to a full period after the event
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_reg <= '0;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

endmodule : holdoff_prescaler

// *** rtl/input_revalidate.sv ***
/*
  Loss-of-signal flag and re-validation counter for one reference input.
  Assumes the input monitor supplies one-cycle pulses for a detected
  loss, a good input period and a missing input edge.
*/
`timescale 1ns/1ps
module input_revalidate
  import refsel_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Monitor events
  input  wire logic       los_event,
  input  wire logic       period_ok,
  input  wire logic       edge_missing,
  // Setting
  input  wire logic [1:0] cntv_sel,
  // State
  output logic            los_flag
);

  logic       los_reg;
  logic [6:0] cnt_reg;
  logic       reload;
  logic       expire;

  // A miss or a fresh loss restarts the good-period run
  assign reload   = los_event || edge_missing;
  assign expire   = los_reg && !reload && period_ok && (cnt_reg == 7'h01);
  assign los_flag = los_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      los_reg <= 1'b0;
      cnt_reg <= revalid_count(CNTV_RST);
    end else if (reload) begin
      los_reg <= los_reg || los_event;
      cnt_reg <= revalid_count(cntv_sel);
    end else if (expire) begin
      los_reg <= 1'b0;
      cnt_reg <= revalid_count(cntv_sel);
    end else if (los_reg && period_ok) begin
      cnt_reg <= cnt_reg - 7'h01;
    end
  end

endmodule : input_revalidate

// *** rtl/reference_input_select_holdoff.sv ***
/*
  Reference input selection for the first PLL: manual, automatic and
  holdover modes, hold-off failover timing and the reference switching
  register set at byte addresses 0x34 to 0x37.
  Assumes synchronous single-cycle register writes and reads from the
  configuration port, and monitor pulses synchronous to clk_sys, which
  is the reference oscillator clock.
*/
`timescale 1ns/1ps

// Summary of operation
// - Two-bit mode: 00 manual, 01 auto, 10 short holdover, 11 auto hold-off.
// - Mode field resets to 00, manual selection.
// - Modes 00 and 10 route the input named by manual select.
// - Auto modes choose by loss-of-signal state and input priorities.
// - Pin-driven input choice overrides the mode field's choice.
// - Manual select 00 is input 0, 01 input 1; resets to 00.
// - In auto modes the manual select field is ignored.
// - Hold-off counter and divider act only in mode 11.
// - A loss event starts the hold-off count from its programmed value.
// - Hold-off count reaching zero starts a failover switch, or holdover if no input is a candidate.
// - After reaching zero the counter reloads the programmed value.
// - Counter steps once per divided oscillator tick.
// - Divider codes select 2^15 to 2^18; resets to 00.
// - Hold-off count register resets to 0x80.
// - Priorities 0 to 3; priority 0 is never auto-selected.
// - Lost input becomes valid again when re-validation count hits zero.
module reference_input_select_holdoff
  import refsel_pkg::*;
#(
  parameter int DIV_EXP_BASE = HOLDOFF_DIV_EXP_BASE
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Configuration register port
  input  wire logic       cfg_wr,
  input  wire logic       cfg_rd,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  output logic      [7:0] cfg_rdata,
  // Input monitor events, one per reference input
  input  wire logic [1:0] los_event,
  input  wire logic [1:0] period_ok,
  input  wire logic [1:0] edge_missing,
  // Pin-driven input choice
  input  wire logic       gpio_sel_en,
  input  wire logic       gpio_sel,
  // Selection results
  output logic            ref_sel,
  output logic            holdover,
  output logic            failover,
  output logic [1:0]      los_flags,
  output logic            block_lor
);

  // Register fields
  logic [1:0] prio0_reg;
  logic [1:0] prio1_reg;
  logic       block_reg;
  logic       revs_reg;
  logic [1:0] mode_reg;
  logic [1:0] sel_reg;
  logic [7:0] holdoff_reg;
  logic [1:0] divsel_reg;
  logic [1:0] cntv_reg;

  // Selection state
  auto_state_e state_reg;
  auto_state_e state_next;
  logic        auto_sel_reg;
  logic        auto_sel_next;
  logic [7:0]  hcnt_reg;
  logic [7:0]  hcnt_next;
  logic        ref_sel_reg;
  logic        holdover_reg;
  logic        failover_reg;
  logic        failover_next;
  logic [1:0]  los_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;

  // Decoded helpers
  logic [1:0] los_now;
  logic [1:0] cand_ok;
  logic       best_sel;
  logic       best_ok;
  logic       auto_mode;
  logic       holdoff_mode;
  logic       cur_lost;
  logic       tick;
  logic       prescale_restart;
  logic       hcnt_zero_step;
  logic       manual_sel;
  logic       mode_sel;
  logic       eff_sel;
  logic       wr_prio;
  logic       wr_sw;
  logic       wr_hold;
  logic       wr_div;

  // Write strobes per register address
  // Unmapped addresses raise no strobe, so such writes are dropped
  assign wr_prio = cfg_wr && (cfg_addr == ADDR_PRIORITY);
  assign wr_sw   = cfg_wr && (cfg_addr == ADDR_SWITCHING);
  assign wr_hold = cfg_wr && (cfg_addr == ADDR_HOLDOFF);
  assign wr_div  = cfg_wr && (cfg_addr == ADDR_DIVIDERS);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prio0_reg   <= PRIO0_RST;
      prio1_reg   <= PRIO1_RST;
      block_reg   <= 1'b0;
      revs_reg    <= 1'b0;
      mode_reg    <= MODE_RST;
      sel_reg     <= SEL_RST;
      holdoff_reg <= HOLDOFF_RST;
      divsel_reg  <= DIVSEL_RST;
      cntv_reg    <= CNTV_RST;
    end else begin
      if (wr_prio) begin
        prio0_reg <= cfg_wdata[PRIO0_LSB +: 2];
        prio1_reg <= cfg_wdata[PRIO1_LSB +: 2];
      end
      if (wr_sw) begin
        block_reg <= cfg_wdata[BLOCK_BIT];
        revs_reg  <= cfg_wdata[REVS_BIT];
        mode_reg  <= cfg_wdata[MODE_LSB +: 2];
        sel_reg   <= cfg_wdata[SEL_LSB +: 2];
      end
      if (wr_hold) begin
        holdoff_reg <= cfg_wdata;
      end
      if (wr_div) begin
        divsel_reg <= cfg_wdata[DIVSEL_LSB +: 2];
        cntv_reg   <= cfg_wdata[CNTV_LSB +: 2];
      end
    end
  end

  // Read mux; reserved bits read as zero
  // Registered below, so read data stands one cycle after the read
  always_comb begin
    rdata_next = 8'h00;
    if (cfg_rd) begin
      case (cfg_addr)
        ADDR_PRIORITY: begin
          rdata_next[PRIO0_LSB +: 2] = prio0_reg;
          rdata_next[PRIO1_LSB +: 2] = prio1_reg;
        end
        ADDR_SWITCHING: begin
          rdata_next[BLOCK_BIT]      = block_reg;
          rdata_next[REVS_BIT]       = revs_reg;
          rdata_next[MODE_LSB +: 2]  = mode_reg;
          rdata_next[SEL_LSB +: 2]   = sel_reg;
        end
        ADDR_HOLDOFF: rdata_next = holdoff_reg;
        ADDR_DIVIDERS: begin
          rdata_next[DIVSEL_LSB +: 2] = divsel_reg;
          rdata_next[CNTV_LSB +: 2]   = cntv_reg;
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // One loss flag and re-validation counter per reference input
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_input
      input_revalidate u_reval (
        .clk_sys      (clk_sys),
        .srst         (srst),
        .los_event    (los_event[gi]),
        .period_ok    (period_ok[gi]),
        .edge_missing (edge_missing[gi]),
        .cntv_sel     (cntv_reg),
        .los_flag     (los_now[gi])
      );
    end
  endgenerate

  // A lost input stays out until its re-validation count runs out
  // priority zero excluded
  assign cand_ok[0] = !los_now[0] && (prio0_reg != 2'h0);
  assign cand_ok[1] = !los_now[1] && (prio1_reg != 2'h0);

  // best by priority
  // Ties go to input 0, which ranks first within equal priority
  assign best_sel = cand_ok[1] && (!cand_ok[0] || (prio1_reg > prio0_reg));
  assign best_ok  = |cand_ok;

  assign auto_mode    = mode_reg[0];
  assign holdoff_mode = (mode_reg == MODE_AUTO_HOLDOFF);
  // Loss on the input that the automatic choice follows
  assign cur_lost     = los_now[auto_sel_reg];

  // Prescaler is realigned when a hold-off period begins
  // so the first tick lands a full divided period after the loss
  assign prescale_restart = (state_reg == ST_TRACK) && (state_next ==
                            ST_HOLDOFF);

  holdoff_prescaler #(
    .EXP_BASE (DIV_EXP_BASE)
  ) u_prescale (
    .clk_sys (clk_sys),
    .srst    (srst),
    .restart (prescale_restart),
    .div_sel (divsel_reg),
    .tick    (tick)
  );

  // zero transition
  // A programmed count of zero expires on the first tick
  // Testing for one lets the switch start on the tick reaching zero
  assign hcnt_zero_step = tick && (hcnt_reg <= 8'h01);

  // Automatic selection state machine
  always_comb begin
    state_next    = state_reg;
    auto_sel_next = auto_sel_reg;
    hcnt_next     = hcnt_reg;
    failover_next = 1'b0;
    if (!auto_mode) begin
      // Manual modes park the automatic choice on the best candidate,
      // so entering an automatic mode starts from a legal input
      state_next    = ST_TRACK;
      hcnt_next     = holdoff_reg;
      auto_sel_next = best_ok ? best_sel : auto_sel_reg;
    end else begin
      unique case (state_reg)
        ST_TRACK: begin
          hcnt_next = holdoff_reg;
          if (cur_lost && holdoff_mode) begin
            state_next = ST_HOLDOFF;
          end else if (cur_lost && best_ok) begin
            auto_sel_next = best_sel;
            failover_next = 1'b1;
          end else if (cur_lost) begin
            state_next = ST_HOLDOVER;
          end else if (revs_reg && best_ok && (best_sel != auto_sel_reg)) begin
            // Revertive switch toward the best candidate, input 0 on equal priority
            auto_sel_next = best_sel;
            failover_next = 1'b1;
          end else if (!cand_ok[auto_sel_reg] && best_ok) begin
            auto_sel_next = best_sel;
            failover_next = 1'b1;
          end
        end
        ST_HOLDOFF: begin
          if (!holdoff_mode || !cur_lost) begin
            // Input recovered or mode changed before expiry
            state_next = ST_TRACK;
            hcnt_next  = holdoff_reg;
          end else if (hcnt_zero_step) begin
            hcnt_next = holdoff_reg;
            if (best_ok) begin
              auto_sel_next = best_sel;
              failover_next = 1'b1;
              state_next    = ST_TRACK;
            end else begin
              state_next = ST_HOLDOVER;
            end
          end else if (tick) begin
            hcnt_next = hcnt_reg - 8'h01;
          end
        end
        ST_HOLDOVER: begin
          // No candidate yet: stay on the lost input until one returns
          hcnt_next = holdoff_reg;
          if (!cur_lost) begin
            state_next = ST_TRACK;
          end else if (best_ok) begin
            auto_sel_next = best_sel;
            failover_next = 1'b1;
            state_next    = ST_TRACK;
          end
        end
        default: begin
          state_next = ST_TRACK;
        end
      endcase
    end
  end

  // select decode
  // Reserved select codes fall back on their low bit
  assign manual_sel = sel_reg[0];
  assign mode_sel   = auto_mode ? auto_sel_next : manual_sel;
  assign eff_sel    = gpio_sel_en ? gpio_sel : mode_sel;

  // State and output registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg    <= ST_TRACK;
      auto_sel_reg <= 1'b0;
      hcnt_reg     <= HOLDOFF_RST;
      ref_sel_reg  <= 1'b0;
      holdover_reg <= 1'b0;
      failover_reg <= 1'b0;
      los_reg      <= 2'b00;
      rdata_reg    <= 8'h00;
    end else begin
      state_reg    <= state_next;
      auto_sel_reg <= auto_sel_next;
      hcnt_reg     <= hcnt_next;
      ref_sel_reg  <= eff_sel;
      // Holdover follows the routed input, pin override included
      holdover_reg <= los_now[eff_sel];
      failover_reg <= failover_next;
      los_reg      <= los_now;
      rdata_reg    <= rdata_next;
    end
  end

  // All outputs come straight from flip-flops
  assign ref_sel   = ref_sel_reg;
  assign holdover  = holdover_reg;
  assign failover  = failover_reg;
  assign los_flags = los_reg;
  // block_lor is stored only; loss-of-reference gating lies outside
  assign block_lor = block_reg;
  assign cfg_rdata = rdata_reg;

endmodule : reference_input_select_holdoff

// *** verification/ref_inputs_model.sv ***
/*
  Behavioural model of the two redundant reference inputs and their
  monitors. Assumes the bench drives alive at clock edges.
*/
`timescale 1ns/1ps
module ref_inputs_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // Wanted input state, one bit per input
  input  wire logic [1:0] alive,
  // Monitor pulses
  output logic      [1:0] los_event,
  output logic      [1:0] period_ok,
  output logic      [1:0] edge_missing
);
  logic [1:0] alive_reg;
  logic [1:0] phase_reg;

  // One input period is four oscillator cycles
  always_ff @(posedge clk_sys) begin
    phase_reg <= srst ? 2'h0 : phase_reg + 2'h1;
    alive_reg <= srst ? 2'h3 : alive;
  end

  // Loss is one pulse; dead inputs keep reporting missing edges
  assign los_event    = alive_reg & ~alive;
  assign period_ok    = (phase_reg == 2'h3) ? alive : 2'h0;
  assign edge_missing = (phase_reg == 2'h3) ? ~alive : 2'h0;
endmodule : ref_inputs_model

// *** verification/refsel_assertions.sv ***
/*
  Port-level checker for the reference selection block.
  Assumes it is bound to the top module of the block.
*/
`timescale 1ns/1ps
module refsel_checker (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       srst,
  // Watched ports
  input wire logic       cfg_rd,
  input wire logic [7:0] cfg_rdata,
  input wire logic [1:0] los_event,
  input wire logic [1:0] period_ok,
  input wire logic       gpio_sel_en,
  input wire logic       gpio_sel,
  input wire logic       ref_sel,
  input wire logic       failover,
  input wire logic [1:0] los_flags
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // Outputs leave reset quiet
  a_reset_quiet: assert property ($fell(srst) |-> !ref_sel && !failover
    && los_flags == 2'b00) else $error("outputs not idle after reset");
  a_rdata_idle: assert property (!cfg_rd |=> cfg_rdata == 8'h00)
    else $error("read data not zero without read");
  a_pin_high: assert property ((gpio_sel_en && gpio_sel)[*3] |-> ref_sel)
    else $error("pin choice of input 1 ignored");
  a_pin_low: assert property ((gpio_sel_en && !gpio_sel)[*3] |-> !ref_sel)
    else $error("pin choice of input 0 ignored");
  a_failover_pulse: assert property (failover |=> !failover)
    else $error("failover longer than one cycle");
  a_failover_moves: assert property (failover && !gpio_sel_en
    |-> ref_sel != $past(ref_sel)) else $error("failover without switch");
  a_loss_flag0: assert property (los_event[0] |-> ##2 los_flags[0])
    else $error("loss on input 0 not flagged");
  a_loss_flag1: assert property (los_event[1] |-> ##2 los_flags[1])
    else $error("loss on input 1 not flagged");
  a_flag_clear: assert property ($fell(los_flags[0])
    |-> $past(period_ok[0], 2)) else $error("flag cleared without period");

  // Main scenarios reached
  c_failover: cover property (failover);
  c_revalid: cover property ($fell(los_flags[0]));
  c_pin: cover property (gpio_sel_en && gpio_sel);
endmodule : refsel_checker

bind reference_input_select_holdoff refsel_checker checker_u (
  .clk_sys(clk_sys), .srst(srst), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
  .los_event(los_event), .period_ok(period_ok), .gpio_sel_en(gpio_sel_en),
  .gpio_sel(gpio_sel), .ref_sel(ref_sel), .failover(failover),
  .los_flags(los_flags));

// *** verification/testbench.sv ***
/*
  Self-checking bench for the reference selection block.
  Assumes the package, design, model and checker are compiled first.
*/
`timescale 1ns/1ps
module testbench import refsel_pkg::*;;
  logic       clk_sys = 1'b0, srst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic       gpio_sel_en = 1'b0, gpio_sel = 1'b0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
  logic [1:0] alive = 2'b11, los_event, period_ok, edge_missing, los_flags;
  logic       ref_sel, holdover, failover, block_lor;
  int         err_total = 0, tests_run = 0, cycles = 0, n;

  // Short hold-off ticks: 2^(2 + divider code) cycles
  reference_input_select_holdoff #(.DIV_EXP_BASE(2)) dut_u (
    .clk_sys(clk_sys), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .los_event(los_event), .period_ok(period_ok),
    .edge_missing(edge_missing), .gpio_sel_en(gpio_sel_en),
    .gpio_sel(gpio_sel), .ref_sel(ref_sel), .holdover(holdover),
    .failover(failover), .los_flags(los_flags), .block_lor(block_lor));
  ref_inputs_model inputs_u (.clk_sys(clk_sys), .srst(srst), .alive(alive),
    .los_event(los_event), .period_ok(period_ok),
    .edge_missing(edge_missing));

  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // Hang guard far above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic do_reset;
    @(posedge clk_sys);
    alive <= 2'b11;
    srst <= 1'b1;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
  endtask : do_reset

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask : reg_write

  // Read data stands for one cycle after the taking edge
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    #1 d = cfg_rdata;
  endtask : reg_read

  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle

  // Cycles from the stimulus edge to a failover pulse, bounded
  task automatic wait_fail(input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_sys);
      #1 cnt++;
    end while (failover !== 1'b1 && cnt < lim);
  endtask : wait_fail

  task automatic lose(input logic [1:0] a);
    @(posedge clk_sys);
    alive <= a;
  endtask : lose

  task automatic t_defaults;
    logic [7:0] d;
    reg_read(ADDR_PRIORITY, d);
    check(d, 8'hE0);
    reg_read(ADDR_SWITCHING, d);
    check(d, 8'h00);
    reg_read(ADDR_HOLDOFF, d);
    check(d, 8'h80);
    reg_read(ADDR_DIVIDERS, d);
    check(d, 8'h00);
    reg_read(8'h40, d);
    check(d, 8'h00);
    check(8'(ref_sel), 8'h00);
    $display("t_defaults done");
  endtask : t_defaults

  // only legal select codes are written
  task automatic t_manual;
    logic [7:0] d;
    reg_write(ADDR_SWITCHING, 8'h08);
    settle();
    check(8'(ref_sel), 8'h00);
    reg_write(ADDR_SWITCHING, 8'h41);
    settle();
    check(8'(ref_sel), 8'h01);
    check(8'(block_lor), 8'h01);
    reg_read(ADDR_SWITCHING, d);
    check(d, 8'h41);
    @(posedge clk_sys);
    gpio_sel_en <= 1'b1;
    settle();
    check(8'(ref_sel), 8'h00);
    @(posedge clk_sys);
    gpio_sel <= 1'b1;
    settle();
    check(8'(ref_sel), 8'h01);
    @(posedge clk_sys);
    gpio_sel_en <= 1'b0;
    gpio_sel <= 1'b0;
    $display("t_manual done");
  endtask : t_manual

  // automatic choice ignores the select field
  task automatic t_auto;
    do_reset();
    reg_write(ADDR_SWITCHING, 8'h05);
    settle();
    check(8'(ref_sel), 8'h00);
    lose(2'b10);
    wait_fail(20, n);
    check(8'(n <= 4), 8'h01);
    check(8'(ref_sel), 8'h01);
    check(8'(los_flags), 8'h01);
    lose(2'b11);
    repeat (20) @(posedge clk_sys);
    #1 check(8'(los_flags), 8'h00);
    check(8'(ref_sel), 8'h01);
    // Revertive switching returns to the higher priority input
    reg_write(ADDR_SWITCHING, 8'h25);
    wait_fail(10, n);
    check(8'(failover), 8'h01);
    check(8'(ref_sel), 8'h00);
    $display("t_auto done");
  endtask : t_auto

  // a priority 0 input is never chosen
  task automatic t_prio0;
    do_reset();
    reg_write(ADDR_PRIORITY, 8'h10);
    reg_write(ADDR_SWITCHING, 8'h04);
    settle();
    check(8'(ref_sel), 8'h01);
    reg_write(ADDR_PRIORITY, 8'hC0);
    wait_fail(10, n);
    check(8'(failover), 8'h01);
    check(8'(ref_sel), 8'h00);
    lose(2'b10);
    wait_fail(40, n);
    check(8'(failover), 8'h00);
    check(8'(ref_sel), 8'h00);
    check(8'(holdover), 8'h01);
    $display("t_prio0 done");
  endtask : t_prio0

  // hold-off delay is count times tick period
  task automatic t_holdoff;
    do_reset();
    reg_write(ADDR_HOLDOFF, 8'h03);
    reg_write(ADDR_SWITCHING, 8'h0C);
    settle();
    lose(2'b10);
    wait_fail(60, n);
    check(8'(failover), 8'h01);
    check(8'(n >= 10 && n <= 20), 8'h01);
    check(8'(ref_sel), 8'h01);
    lose(2'b11);
    repeat (20) @(posedge clk_sys);
    reg_write(ADDR_HOLDOFF, 8'h02);
    reg_write(ADDR_DIVIDERS, 8'h41);
    settle();
    lose(2'b01);
    wait_fail(60, n);
    check(8'(n >= 14 && n <= 24), 8'h01);
    check(8'(ref_sel), 8'h00);
    // Re-validation setting 01 needs 16 good periods of 4 cycles
    lose(2'b11);
    repeat (40) @(posedge clk_sys);
    #1 check(8'(los_flags), 8'h02);
    repeat (40) @(posedge clk_sys);
    #1 check(8'(los_flags), 8'h00);
    $display("t_holdoff done");
  endtask : t_holdoff

  initial begin
    do_reset();
    t_defaults();
    t_manual();
    t_auto();
    t_prio0();
    t_holdoff();
    give_verdict();
  end
endmodule : testbench
